// *** rtl/ldr_defs.svh ***
// constants of the logical-device interrupt and dma routing block
// assumes it is included by bare name from the package and the top module
`ifndef LDR_DEFS_SVH
`define LDR_DEFS_SVH

`define LDR_NDEV          16
// configuration register indexes
`define LDR_IDX_LDN       8'h07
`define LDR_IDX_OSC       8'h24
`define LDR_IDX_PORT_LO   8'h26
`define LDR_IDX_PORT_HI   8'h27
`define LDR_IDX_ACT       8'h30
`define LDR_IDX_BASE_HI   8'h60
`define LDR_IDX_BASE_LO   8'h61
`define LDR_IDX_IRQ       8'h70
`define LDR_IDX_DMA       8'h74
// field positions
`define LDR_OSC_A16_BIT   6
// configuration port placement
`define LDR_PORT_STRAP0   12'h02E
`define LDR_PORT_STRAP1   12'h04E
`define LDR_PORT_MIN      12'h100
`define LDR_PORT_MAX      12'hFFE
// logical device numbers
`define LDR_LD_FDC        4'h0
`define LDR_LD_PP         4'h3
`define LDR_LD_UART       4'h4
`define LDR_LD_MIDI       4'h5
`define LDR_LD_KBD        4'h7
`define LDR_LD_GAME       4'h9
`define LDR_LD_RT         4'hA
`define LDR_LD_TW         4'hB
// base ranges and alignment masks
`define LDR_BASE_MIN      12'h100
`define LDR_BASE_MAX8     12'hFF8
`define LDR_BASE_MAX4     12'hFFC
`define LDR_BASE_MAX1     12'hFFF
`define LDR_BASE_MAXRT    12'hF7F
`define LDR_MASK8         12'hFF8
`define LDR_MASK4         12'hFFC
`define LDR_MASK1         12'hFFF
`define LDR_MASK128       12'hF80
`define LDR_KBD_DATA      12'h060
`define LDR_KBD_CMD       12'h064
// reset values
`define LDR_DMA_RST_FDC   3'h2
`define LDR_DMA_RST_OTHER 3'h4
`define LDR_DMA_NONE      3'h4
`define LDR_IRQ_NONE      4'h0
`define LDR_IRQ_SMI       4'h2
// parallel extended-mode codes that force the interrupt on
`define LDR_ECR_FIFO      3'h2
`define LDR_ECR_ECP       3'h3
`define LDR_ECR_TEST      3'h6

`endif

// *** rtl/ldr_pkg.sv ***
// types of the logical-device interrupt and dma routing block
// assumes ldr_defs.svh is on the include path
`include "ldr_defs.svh"

package ldr_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ldr_io_req_t;

    typedef struct packed {
        logic       floppy_dma_gate;
        logic       floppy_powerdown;
        logic       parallel_irq_gate;
        logic       parallel_ecp_mode;
        logic [2:0] parallel_ecr_mode;
        logic       ecp_service_interrupt_bit;
        logic       ecp_dma_gate;
        logic [3:0] uart_interrupt_enable_reg;
        logic       modem_aux_output_two;
        logic       twowire_interrupt_enable;
    } ldr_dev_status_t;

    typedef struct packed {
        logic       wr;
        logic [3:0] dev;
        logic       value;
    } ldr_pwr_ctl_t;

    typedef struct packed {
        logic [7:0]                           index;
        logic [3:0]                           ldn;
        logic                                 osc_a16;
        logic [11:0]                          cfg_port;
        logic                                 strap_done;
        logic [`LDR_NDEV-1:0]                 act;
        logic [`LDR_NDEV-1:0][11:0]           base;
        logic [`LDR_NDEV-1:0][3:0]            irq_sel;
        logic [`LDR_NDEV-1:0][2:0]            dma_sel;
        logic [7:0]                           rdata;
        logic                                 rvalid;
        logic [15:0]                          irq_line;
        logic [3:0]                           dma_req;
        logic                                 smi_n;
        logic [`LDR_NDEV-1:0]                 dev_hit;
    } ldr_state_t;

endpackage

// *** rtl/ldr_routing.sv ***
// configuration, address decode and irq/dma routing of the logical devices
// assumes host i/o cycles arrive as one-cycle requests synchronous to clk;
// device enable bits and raw requests come from the logical blocks themselves

`include "ldr_defs.svh"

// How it works
// - decode device bases from address bits 11:0
// - 16-bit qualify needs oscillator bit6, upper zero
// - config port at 02E/04E by strap, movable
// - relocated port 0100 to 0FFE, even only
// - index at port, data at port plus one
// - level select 0 none, 1..15 IRQ lines
// - interrupts active high, management interrupt active low
// - floppy irq needs level and dma gate
// - parallel irq needs gate or a forcing ecr mode, service bit clear in extended mode
// - uart irq needs ier bit and aux2
// - unselected levels stay off, all fifteen usable
// - dma select 1..3 channels, 4..7 none
// - dma active needs channel and gate bit
// - dma select resets to 2 floppy, 4 parallel
// - block disable bits suppress irq and dma
// - floppy off when gate clear or powered down
// - uart irq released while aux2 is zero
// - parallel irq released while gate zero outside the forcing ecr modes
// - extended mode: dma by gate, irq per mode
// - activate and power bit are one bit
// - out-of-range base ignores host cycles
module ldr_routing (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      soft_reset,
    input  wire logic                      config_port_strap,
    // host i/o cycle
    input  wire ldr_pkg::ldr_io_req_t      io_req,
    output logic [7:0]                     io_rdata_ff,
    output logic                           io_rvalid_ff,
    // logical device side
    input  wire ldr_pkg::ldr_dev_status_t  dev_status,
    input  wire logic [`LDR_NDEV-1:0]      dev_irq_raw,
    input  wire logic                      floppy_dreq,
    input  wire logic                      parallel_dreq,
    input  wire logic                      smi_req,
    input  wire ldr_pkg::ldr_pwr_ctl_t     pwr_ctl,
    output logic [`LDR_NDEV-1:0]           dev_active_ff,
    output logic [`LDR_NDEV-1:0]           dev_hit_ff,
    // routed requests
    output logic [15:0]                    irq_line_ff,
    output logic [3:0]                     dma_req_ff,
    output logic                           system_mgmt_interrupt_n_ff
);
    import ldr_pkg::*;

    ldr_state_t st_ff;
    ldr_state_t nxt_st;

    // base register legal for this logical device
    function automatic logic base_ok(input logic [3:0] dev, input logic [11:0] b);
        logic ok;
        ok = 1'b0;
        unique case (dev)
            `LDR_LD_FDC, `LDR_LD_UART, `LDR_LD_MIDI, `LDR_LD_TW:
                ok = (b >= `LDR_BASE_MIN) && (b <= `LDR_BASE_MAX8) && ((b & `LDR_MASK8) == b);
            `LDR_LD_PP:
                ok = (b >= `LDR_BASE_MIN) && (b <= `LDR_BASE_MAX4) && ((b & `LDR_MASK4) == b);
            `LDR_LD_GAME:
                ok = (b >= `LDR_BASE_MIN) && (b <= `LDR_BASE_MAX1);
            `LDR_LD_RT:
                ok = (b <= `LDR_BASE_MAXRT) && ((b & `LDR_MASK128) == b);
            `LDR_LD_KBD:
                ok = 1'b1;
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // address window mask of each logical device
    function automatic logic [11:0] win_mask(input logic [3:0] dev);
        logic [11:0] m;
        m = `LDR_MASK8;
        unique case (dev)
            `LDR_LD_PP:   m = `LDR_MASK4;
            `LDR_LD_GAME: m = `LDR_MASK1;
            `LDR_LD_RT:   m = `LDR_MASK128;
            default:      m = `LDR_MASK8;
        endcase
        return m;
    endfunction

    // a device carrying a dma select register
    function automatic logic has_dma(input logic [3:0] dev);
        return (dev == `LDR_LD_FDC) || (dev == `LDR_LD_PP);
    endfunction

    always_comb begin
        logic        a16_ok;
        logic        port_idx;
        logic        port_dat;
        logic [11:0] a;
        logic [11:0] new_port;
        logic [3:0]  cur;
        logic [`LDR_NDEV-1:0] irq_gate;
        logic [`LDR_NDEV-1:0] valid_dev;
        logic        pp_irq;
        logic        fdc_on;
        logic        fdc_dma;
        logic        pp_dma;
        nxt_st   = st_ff;
        a        = io_req.addr[11:0];
        cur      = st_ff.ldn;
        new_port = st_ff.cfg_port;

        // upper address bits are only checked when 16-bit qualify is on
        a16_ok   = !st_ff.osc_a16 || (io_req.addr[15:12] == 4'h0);
        port_idx = io_req.valid && st_ff.strap_done && a16_ok && (a == st_ff.cfg_port);
        port_dat = io_req.valid && st_ff.strap_done && a16_ok && (a == st_ff.cfg_port + 12'h001);

        // power-on placement of the configuration port from the strap
        if (!st_ff.strap_done) begin
            nxt_st.cfg_port   = config_port_strap ? `LDR_PORT_STRAP1 : `LDR_PORT_STRAP0;
            nxt_st.strap_done = 1'b1;
        end

        nxt_st.rvalid = 1'b0;
        nxt_st.rdata  = 8'h00;

        if (port_idx) begin
            if (io_req.write) begin
                nxt_st.index = io_req.wdata;
            end else begin
                nxt_st.rvalid = 1'b1;
                nxt_st.rdata  = st_ff.index;
            end
        end

        if (port_dat) begin
            if (io_req.write) begin
                unique case (st_ff.index)
                    `LDR_IDX_LDN:     nxt_st.ldn = io_req.wdata[3:0];
                    `LDR_IDX_OSC:     nxt_st.osc_a16 = io_req.wdata[`LDR_OSC_A16_BIT];
                    `LDR_IDX_PORT_LO: new_port = {st_ff.cfg_port[11:8], io_req.wdata[7:1], 1'b0};
                    `LDR_IDX_PORT_HI: new_port = {io_req.wdata[3:0], st_ff.cfg_port[7:0]};
                    `LDR_IDX_ACT:     nxt_st.act[cur] = io_req.wdata[0];
                    `LDR_IDX_BASE_HI: nxt_st.base[cur] = {io_req.wdata[3:0], st_ff.base[cur][7:0]};
                    `LDR_IDX_BASE_LO: nxt_st.base[cur] = {st_ff.base[cur][11:8], io_req.wdata};
                    `LDR_IDX_IRQ:     nxt_st.irq_sel[cur] = io_req.wdata[3:0];
                    `LDR_IDX_DMA: begin
                        if (has_dma(cur)) begin
                            nxt_st.dma_sel[cur] = io_req.wdata[2:0];
                        end
                    end
                    default: ;
                endcase
                // a relocation outside the legal window is dropped
                if ((new_port >= `LDR_PORT_MIN) && (new_port <= `LDR_PORT_MAX)) begin
                    nxt_st.cfg_port = new_port;
                end
            end else begin
                nxt_st.rvalid = 1'b1;
                unique case (st_ff.index)
                    `LDR_IDX_LDN:     nxt_st.rdata = {4'h0, st_ff.ldn};
                    `LDR_IDX_OSC:     nxt_st.rdata = 8'(st_ff.osc_a16) << `LDR_OSC_A16_BIT;
                    `LDR_IDX_PORT_LO: nxt_st.rdata = st_ff.cfg_port[7:0];
                    `LDR_IDX_PORT_HI: nxt_st.rdata = {4'h0, st_ff.cfg_port[11:8]};
                    `LDR_IDX_ACT:     nxt_st.rdata = {7'h00, st_ff.act[cur]};
                    `LDR_IDX_BASE_HI: nxt_st.rdata = {4'h0, st_ff.base[cur][11:8]};
                    `LDR_IDX_BASE_LO: nxt_st.rdata = st_ff.base[cur][7:0];
                    `LDR_IDX_IRQ:     nxt_st.rdata = {4'h0, st_ff.irq_sel[cur]};
                    `LDR_IDX_DMA:     nxt_st.rdata = has_dma(cur) ? {5'h00, st_ff.dma_sel[cur]} : 8'h00;
                    default:          nxt_st.rdata = 8'h00;
                endcase
            end
        end

        // the power-control side writes the same bit as activate
        if (pwr_ctl.wr) begin
            nxt_st.act[pwr_ctl.dev] = pwr_ctl.value;
        end

        // per-device decode of runtime i/o cycles
        for (int d = 0; d < `LDR_NDEV; d++) begin
            valid_dev[d] = st_ff.act[d] && base_ok(4'(d), st_ff.base[d]);
            if (4'(d) == `LDR_LD_KBD) begin
                nxt_st.dev_hit[d] = io_req.valid && a16_ok && st_ff.act[d]
                                    && ((a == `LDR_KBD_DATA) || (a == `LDR_KBD_CMD));
            end else begin
                nxt_st.dev_hit[d] = io_req.valid && a16_ok && valid_dev[d]
                                    && ((a & win_mask(4'(d))) == st_ff.base[d]);
            end
        end

        // block-internal interrupt gates
        fdc_on = dev_status.floppy_dma_gate && !dev_status.floppy_powerdown;
        if (dev_status.parallel_ecp_mode) begin
            unique case (dev_status.parallel_ecr_mode)
                `LDR_ECR_FIFO, `LDR_ECR_ECP, `LDR_ECR_TEST: pp_irq = 1'b1;
                default: pp_irq = dev_status.parallel_irq_gate;
            endcase
            pp_irq = pp_irq && !dev_status.ecp_service_interrupt_bit;
        end else begin
            pp_irq = dev_status.parallel_irq_gate;
        end
        for (int d = 0; d < `LDR_NDEV; d++) begin
            irq_gate[d] = valid_dev[d];
        end
        irq_gate[`LDR_LD_FDC]  = valid_dev[`LDR_LD_FDC] && fdc_on;
        irq_gate[`LDR_LD_PP]   = valid_dev[`LDR_LD_PP] && pp_irq;
        irq_gate[`LDR_LD_UART] = valid_dev[`LDR_LD_UART]
                                 && (dev_status.uart_interrupt_enable_reg != 4'h0)
                                 && dev_status.modem_aux_output_two;
        irq_gate[`LDR_LD_TW]   = valid_dev[`LDR_LD_TW]
                                 && dev_status.twowire_interrupt_enable;

        // fold each enabled device onto its selected level; unused levels stay low
        nxt_st.irq_line = 16'h0000;
        for (int d = 0; d < `LDR_NDEV; d++) begin
            if ((st_ff.irq_sel[d] != `LDR_IRQ_NONE) && irq_gate[d] && dev_irq_raw[d]) begin
                nxt_st.irq_line[st_ff.irq_sel[d]] = 1'b1;
            end
        end

        // the active-low management interrupt is the registered inverse of smi_req
        nxt_st.smi_n = !smi_req;

        // dma routing
        fdc_dma = valid_dev[`LDR_LD_FDC] && fdc_on && floppy_dreq;
        pp_dma  = valid_dev[`LDR_LD_PP] && dev_status.parallel_ecp_mode
                  && dev_status.ecp_dma_gate && parallel_dreq;
        nxt_st.dma_req = 4'h0;
        if (fdc_dma && (st_ff.dma_sel[`LDR_LD_FDC] != 3'h0) && (st_ff.dma_sel[`LDR_LD_FDC] < `LDR_DMA_NONE)) begin
            nxt_st.dma_req[st_ff.dma_sel[`LDR_LD_FDC][1:0]] = 1'b1;
        end
        if (pp_dma && (st_ff.dma_sel[`LDR_LD_PP] != 3'h0) && (st_ff.dma_sel[`LDR_LD_PP] < `LDR_DMA_NONE)) begin
            nxt_st.dma_req[st_ff.dma_sel[`LDR_LD_PP][1:0]] = 1'b1;
        end

        // soft reset returns selects and activation to their defaults
        if (soft_reset) begin
            nxt_st.act     = '0;
            nxt_st.irq_sel = '0;
            for (int d = 0; d < `LDR_NDEV; d++) begin
                nxt_st.dma_sel[d] = (4'(d) == `LDR_LD_FDC) ? `LDR_DMA_RST_FDC : `LDR_DMA_RST_OTHER;
            end
            nxt_st.irq_line = 16'h0000;
            nxt_st.dma_req  = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff            <= '0;
            st_ff.cfg_port   <= `LDR_PORT_STRAP0;
            st_ff.smi_n      <= 1'b1;
            for (int d = 0; d < `LDR_NDEV; d++) begin
                st_ff.dma_sel[d] <= (4'(d) == `LDR_LD_FDC) ? `LDR_DMA_RST_FDC : `LDR_DMA_RST_OTHER;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign io_rdata_ff                = st_ff.rdata;
    assign io_rvalid_ff               = st_ff.rvalid;
    assign dev_active_ff              = st_ff.act;
    assign dev_hit_ff                 = st_ff.dev_hit;
    assign irq_line_ff                = st_ff.irq_line;
    assign dma_req_ff                 = st_ff.dma_req;
    assign system_mgmt_interrupt_n_ff = st_ff.smi_n;

endmodule

// *** verif/ldr_routing_sva.sv ***
// assertions on the ports of the irq/dma routing block
// assumes ldr_defs.svh is on the include path and the block runs on one clock
`include "ldr_defs.svh"
module ldr_routing_chk (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic                     soft_reset,
    // inputs watched
    input wire ldr_pkg::ldr_io_req_t     io_req,
    input wire ldr_pkg::ldr_dev_status_t dev_status,
    input wire logic [`LDR_NDEV-1:0]     dev_irq_raw,
    input wire logic                     floppy_dreq,
    input wire logic                     parallel_dreq,
    input wire logic                     smi_req,
    input wire ldr_pkg::ldr_pwr_ctl_t    pwr_ctl,
    // outputs watched
    input wire logic                     io_rvalid_ff,
    input wire logic [`LDR_NDEV-1:0]     dev_active_ff,
    input wire logic [`LDR_NDEV-1:0]     dev_hit_ff,
    input wire logic [15:0]              irq_line_ff,
    input wire logic [3:0]               dma_req_ff,
    input wire logic                     system_mgmt_interrupt_n_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    import ldr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_smi; !$past(reset) |-> system_mgmt_interrupt_n_ff == !$past(smi_req); endproperty
    a_smi: assert property (p_smi) else $error("management interrupt not inverse of request");
    property p_irq0; irq_line_ff[0] == 1'h0; endproperty
    a_irq0: assert property (p_irq0) else $error("level zero raised");
    property p_dma0; dma_req_ff[0] == 1'h0; endproperty
    a_dma0: assert property (p_dma0) else $error("dma channel zero raised");
    property p_irq_src; dev_irq_raw == '0 |=> irq_line_ff == '0; endproperty
    a_irq_src: assert property (p_irq_src) else $error("level raised without request");
    property p_dma_src; !floppy_dreq && !parallel_dreq |=> dma_req_ff == '0; endproperty
    a_dma_src: assert property (p_dma_src) else $error("dma raised without request");
    property p_fdc_off;
        (!dev_status.floppy_dma_gate || dev_status.floppy_powerdown)
            && !(dev_status.parallel_ecp_mode && dev_status.ecp_dma_gate) |=> dma_req_ff == '0;
    endproperty
    a_fdc_off: assert property (p_fdc_off) else $error("dma raised with gates closed");
    property p_uart_off;
        dev_irq_raw == (16'h1 << `LDR_LD_UART) && !dev_status.modem_aux_output_two |=> irq_line_ff == '0;
    endproperty
    a_uart_off: assert property (p_uart_off) else $error("serial irq raised with aux2 clear");
    property p_rvalid; io_rvalid_ff |-> $past(io_req.valid) && !$past(io_req.write); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read data without read request");
    property p_hit; dev_hit_ff != '0 |-> $past(io_req.valid); endproperty
    a_hit: assert property (p_hit) else $error("device hit without request");
    property p_soft; soft_reset |=> irq_line_ff == '0 && dma_req_ff == '0 && dev_active_ff == '0; endproperty
    a_soft: assert property (p_soft) else $error("soft reset left requests on");
    property p_pwr;
        pwr_ctl.wr && !soft_reset |=> dev_active_ff[$past(pwr_ctl.dev)] == $past(pwr_ctl.value);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power bit not mirrored in activate");
endmodule

bind ldr_routing ldr_routing_chk u_chk (.clk(clk), .reset(reset), .soft_reset(soft_reset), .io_req(io_req),
    .dev_status(dev_status), .dev_irq_raw(dev_irq_raw), .floppy_dreq(floppy_dreq),
    .parallel_dreq(parallel_dreq), .smi_req(smi_req), .pwr_ctl(pwr_ctl), .io_rvalid_ff(io_rvalid_ff),
    .dev_active_ff(dev_active_ff), .dev_hit_ff(dev_hit_ff), .irq_line_ff(irq_line_ff),
    .dma_req_ff(dma_req_ff), .system_mgmt_interrupt_n_ff(system_mgmt_interrupt_n_ff));

// *** verif/ldr_host_model.sv ***
// host model issuing configuration and device i/o cycles
// assumes reads are answered by a one-cycle pulse one edge after the request
`include "ldr_defs.svh"
module ldr_host_model (
    // clock
    input wire logic              clk,
    // host i/o cycle
    output ldr_pkg::ldr_io_req_t  io_req,
    input wire logic [7:0]        io_rdata_ff,
    input wire logic              io_rvalid_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    import ldr_pkg::*;
    logic [11:0] port = `LDR_PORT_STRAP0;
    initial io_req = '0;
    // released lines show the inverse so stale values never pass
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
        @(negedge clk);
        io_req = '{valid: 1'h1, write: wr, addr: a, wdata: wd};
        @(negedge clk);
        io_req = '{valid: 1'h0, write: ~wr, addr: ~a, wdata: ~wd};
        rd = io_rdata_ff;
        ok = io_rvalid_ff;
    endtask
    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] rd;
        logic       ok;
        io(1'h1, {4'h0, port}, idx, rd, ok);
        io(1'h1, {4'h0, port + 12'h1}, v, rd, ok);
    endtask
    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] v, output logic ok);
        io(1'h1, {4'h0, port}, idx, v, ok);
        io(1'h0, {4'h0, port + 12'h1}, 8'h00, v, ok);
    endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench: host model plus random device gates against the routing block
// assumes design, checker and host model are compiled first
`include "ldr_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ldr_pkg::*;
    logic            clk = 1'h0, reset = 1'h1, soft_reset = 1'h0, fdq = 1'h0, pdq = 1'h0, smi = 1'h0;
    logic            strap = 1'h0;
    ldr_io_req_t     io_req;
    ldr_dev_status_t st = '0;
    ldr_pwr_ctl_t    pwr = '0;
    logic [15:0]     raw = '0, irq_line, act_o, hit;
    logic [7:0]      rdata, rd;
    logic            rvalid, smi_n, ok;
    logic [3:0]      dma, lvl, sel [16];
    logic [2:0]      dsel [16];
    logic            act [16];
    int              fail_count = 0, cmp_count = 0;
    always #20 clk = ~clk;
    ldr_routing i_dut (.clk(clk), .reset(reset), .soft_reset(soft_reset), .config_port_strap(strap),
        .io_req(io_req), .io_rdata_ff(rdata), .io_rvalid_ff(rvalid), .dev_status(st), .dev_irq_raw(raw),
        .floppy_dreq(fdq), .parallel_dreq(pdq), .smi_req(smi), .pwr_ctl(pwr), .dev_active_ff(act_o),
        .dev_hit_ff(hit), .irq_line_ff(irq_line), .dma_req_ff(dma), .system_mgmt_interrupt_n_ff(smi_n));
    ldr_host_model i_host (.clk(clk), .io_req(io_req), .io_rdata_ff(rdata), .io_rvalid_ff(rvalid));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] exp_irq();
        logic [15:0] e;
        logic        g;
        e = '0;
        for (int d = 0; d < 16; d++) begin
            case (d)
                `LDR_LD_FDC:  g = st.floppy_dma_gate && !st.floppy_powerdown;
                `LDR_LD_PP:   g = st.parallel_ecp_mode ? !st.ecp_service_interrupt_bit && (st.parallel_irq_gate
                    || st.parallel_ecr_mode inside {`LDR_ECR_FIFO, `LDR_ECR_ECP, `LDR_ECR_TEST})
                    : st.parallel_irq_gate;
                `LDR_LD_UART: g = (|st.uart_interrupt_enable_reg) && st.modem_aux_output_two;
                `LDR_LD_TW:   g = st.twowire_interrupt_enable;
                default:      g = 1'h1;
            endcase
            if (raw[d] && g && act[d] && sel[d] != 4'h0) e[sel[d]] = 1'h1;
        end
        return e;
    endfunction
    function automatic logic [3:0] exp_dma();
        logic [3:0] e;
        e = '0;
        if (act[0] && fdq && st.floppy_dma_gate && !st.floppy_powerdown && dsel[0] inside {[3'h1:3'h3]})
            e[dsel[0]] = 1'h1;
        if (act[3] && pdq && st.parallel_ecp_mode && st.ecp_dma_gate && dsel[3] inside {[3'h1:3'h3]})
            e[dsel[3]] = 1'h1;
        return e;
    endfunction
    task automatic set_dev(input logic [3:0] ld, input logic [11:0] base, input logic [3:0] l, input logic h);
        i_host.cfg_wr(`LDR_IDX_LDN, {4'h0, ld});
        i_host.cfg_wr(`LDR_IDX_BASE_HI, {4'h0, base[11:8]});
        i_host.cfg_wr(`LDR_IDX_BASE_LO, base[7:0]);
        i_host.cfg_wr(`LDR_IDX_ACT, 8'h01);
        i_host.cfg_wr(`LDR_IDX_IRQ, {4'h0, l});
        act[ld] = 1'h1;
        sel[ld] = l;
        i_host.cfg_rd(`LDR_IDX_IRQ, rd, ok);
        check("irq select", {7'h00, ok, rd}, {8'h01, 4'h0, l});
        i_host.io(1'h0, {4'h0, base}, 8'h00, rd, ok);
        check("device hit", 16'(hit[ld]), 16'(h));
    endtask
    task automatic set_dma(input logic [3:0] ld, input logic [2:0] v);
        i_host.cfg_wr(`LDR_IDX_LDN, {4'h0, ld});
        i_host.cfg_wr(`LDR_IDX_DMA, {5'h00, v});
        dsel[ld] = v;
    endtask
    task automatic defaults();
        for (int d = 0; d < 16; d++) begin
            sel[d] = 4'h0;
            act[d] = 1'h0;
            dsel[d] = (d == 0) ? `LDR_DMA_RST_FDC : `LDR_DMA_RST_OTHER;
        end
        foreach (dsel[d]) if (d == 0 || d == 3) begin
            i_host.cfg_wr(`LDR_IDX_LDN, 8'(d));
            i_host.cfg_rd(`LDR_IDX_DMA, rd, ok);
            check("dma default", {7'h00, ok, rd}, {8'h01, 5'h00, dsel[d]});
        end
    endtask
    task automatic rand_phase(input int n);
        repeat (n) begin
            @(negedge clk);
            st = $bits(st)'($urandom);
            raw = 16'($urandom);
            {fdq, pdq, smi} = 3'($urandom);
            @(negedge clk);
            check("irq lines", irq_line, exp_irq());
            check("dma requests", 16'(dma), 16'(exp_dma()));
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(20620));
        repeat (2) @(negedge clk);
        reset = 1'h0;
        @(negedge clk);
        defaults();
        set_dev(`LDR_LD_TW, 12'h0F8, 4'h9, 1'h0);
        set_dev(`LDR_LD_TW, 12'h200, 4'h9, 1'h1);
        set_dev(`LDR_LD_PP, 12'h378, 4'h7, 1'h1);
        set_dev(`LDR_LD_UART, 12'h3F8, 4'h4, 1'h1);
        set_dma(`LDR_LD_PP, 3'h3);
        rand_phase(150);
        repeat (20) begin
            lvl = 4'($urandom);
            set_dev(`LDR_LD_FDC, 12'h3F0, lvl, 1'h1);
            set_dma(`LDR_LD_FDC, 3'($urandom));
            rand_phase(5);
        end
        i_host.cfg_wr(`LDR_IDX_OSC, 8'h40);
        i_host.io(1'h0, 16'h13F0, 8'h00, rd, ok);
        check("upper address hit", 16'(hit[0]), 16'h0000);
        @(negedge clk);
        pwr = '{wr: 1'h1, dev: `LDR_LD_UART, value: 1'h0};
        @(negedge clk);
        pwr.wr = 1'h0;
        act[`LDR_LD_UART] = 1'h0;
        check("power bit", 16'(act_o[`LDR_LD_UART]), 16'h0000);
        rand_phase(20);
        soft_reset = 1'h1;
        @(negedge clk);
        soft_reset = 1'h0;
        defaults();
        rand_phase(20);
        i_host.cfg_wr(`LDR_IDX_PORT_HI, 8'h01);
        i_host.port = 12'h12E;
        i_host.cfg_rd(`LDR_IDX_LDN, rd, ok);
        check("moved port", {7'h00, ok, rd}, 16'h0103);
        i_host.cfg_wr(`LDR_IDX_PORT_HI, 8'h00);
        i_host.cfg_rd(`LDR_IDX_LDN, rd, ok);
        check("port kept", {7'h00, ok, rd}, 16'h0103);
        // second reset with the strap high places the port at its other home
        @(negedge clk);
        strap = 1'h1;
        reset = 1'h1;
        repeat (2) @(negedge clk);
        reset = 1'h0;
        @(negedge clk);
        i_host.port = `LDR_PORT_STRAP1;
        i_host.cfg_rd(`LDR_IDX_LDN, rd, ok);
        check("strap port", {7'h00, ok, rd}, 16'h0100);
        give_verdict();
    end
endmodule
